// ### lse_pkg.sv
/*
 * constants and state type for the light sensor enable and timing core.
 * assumes a 40 MHz core clock and a byte-wide register port.
 */
`default_nettype none
package lse_pkg;
	// register offsets
	localparam logic [7:0] ADDR_ENABLE = 8'h80;
	localparam logic [7:0] ADDR_INTEG_LEN = 8'h81;
	localparam logic [7:0] ADDR_WAIT_LEN = 8'h83;
	localparam logic [7:0] ADDR_LTHR_LO = 8'h84;
	localparam logic [7:0] ADDR_LTHR_HI = 8'h85;
	// enable register fields
	localparam int BIT_POWER_UP = 0;
	localparam int BIT_MEASURE = 1;
	localparam int BIT_WAIT_EN = 3;
	// reset values
	localparam logic [7:0] ENABLE_RST = 8'h00;
	localparam logic [7:0] INTEG_LEN_RST = 8'h00;
	localparam logic [7:0] WAIT_LEN_RST = 8'h00;
	localparam logic [7:0] LTHR_RST = 8'h00;
	localparam logic [7:0] TERMINAL_COUNT = 8'h00;
	// timing: core clock down to the rc rate, then to the integration clock
	localparam int MCLK_KHZ = 40000;
	localparam int RC_KHZ = 8000;
	localparam int RC_DIV = MCLK_KHZ / RC_KHZ;
	localparam int INTEG_DIV = 11;
	localparam int TICK_CYCLES = RC_DIV * INTEG_DIV;
	localparam int STEP_TICKS = 2048;
	localparam int STRETCH_FACTOR = 12;
	typedef enum logic [1:0] {
		ST_SLEEP = 2'b00,
		ST_IDLE = 2'b01,
		ST_INTEG = 2'b10,
		ST_WAIT = 2'b11
	} lse_state_t;
endpackage : lse_pkg
`default_nettype wire

// ### lse_core.sv
/*
 * light sensor enable register, integration and wait timers, low threshold.
 * assumes the serial-bus slave turns host accesses into single-cycle
 * register strobes and the converter gives a visible result with a valid.
 */
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - oscillator and converters on only with power-up
// - measure enable bit runs light measurement
// - wait enable bit inserts wait period
// - integration down counter ends at zero
// - integration lasts length plus one steps
// - integration clock is rc rate over eleven
// - one step is 2048 integration clocks
// - wait down counter lasts length plus one
// - wait stretch multiplies wait by twelve
// - visible result compared below 16-bit threshold
// - low byte register is threshold bits 7:0
// - measure then wait repeats while enabled
// - sleep after reset and on power-down
// - low byte buffered, latched on high write
module lse_core #(
	parameter int STEP_TICKS = lse_pkg::STEP_TICKS
) (
	// clock and reset
	input wire logic mclk_in,
	input wire logic nrst_in,
	// register port
	input wire logic [7:0] reg_addr_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [7:0] reg_wdata_in,
	output logic [7:0] reg_rdata_out,
	// configuration and converter
	input wire logic wait_stretch_in,
	input wire logic vis_valid_in,
	input wire logic [15:0] vis_result_in,
	// status
	output logic osc_enable_out,
	output logic conv_enable_out,
	output logic integ_done_out,
	output logic below_low_out,
	output logic [1:0] state_out
);
	logic [7:0] enable_q;
	logic [7:0] integ_len_q;
	logic [7:0] wait_len_q;
	logic [7:0] lthr_lo_q;
	logic [7:0] lthr_hi_q;
	logic [15:0] lthr_q;
	logic [7:0] rdata_q;
	logic below_q;
	logic done_q;
	lse_pkg::lse_state_t state_q, state_d;
	logic [7:0] per_q, per_d;
	logic [3:0] str_q, str_d;
	logic done_d;
	logic [5:0] tick_q;
	logic [11:0] step_q;
	logic tick, step_end, running, power_up, measure, wait_en;

	assign power_up = enable_q[lse_pkg::BIT_POWER_UP];
	assign measure = enable_q[lse_pkg::BIT_MEASURE];
	assign wait_en = enable_q[lse_pkg::BIT_WAIT_EN];

	// register writes
	always_ff @(posedge mclk_in) begin
		if (!nrst_in) begin
			enable_q <= lse_pkg::ENABLE_RST;
			integ_len_q <= lse_pkg::INTEG_LEN_RST;
			wait_len_q <= lse_pkg::WAIT_LEN_RST;
			lthr_lo_q <= lse_pkg::LTHR_RST;
			lthr_hi_q <= lse_pkg::LTHR_RST;
			lthr_q <= {lse_pkg::LTHR_RST, lse_pkg::LTHR_RST};
		end else if (reg_wr_in) begin
			case (reg_addr_in)
				lse_pkg::ADDR_ENABLE: enable_q <= reg_wdata_in;
				lse_pkg::ADDR_INTEG_LEN: integ_len_q <= reg_wdata_in;
				lse_pkg::ADDR_WAIT_LEN: wait_len_q <= reg_wdata_in;
				lse_pkg::ADDR_LTHR_LO: lthr_lo_q <= reg_wdata_in;
				lse_pkg::ADDR_LTHR_HI: begin
					lthr_hi_q <= reg_wdata_in;
					lthr_q <= {reg_wdata_in, lthr_lo_q};
				end
				default: ;
			endcase
		end
	end

	// register reads, unmapped offsets answer zero
	always_ff @(posedge mclk_in) begin
		if (!nrst_in) begin
			rdata_q <= 8'h00;
		end else if (reg_rd_in) begin
			case (reg_addr_in)
				lse_pkg::ADDR_ENABLE: rdata_q <= enable_q;
				lse_pkg::ADDR_INTEG_LEN: rdata_q <= integ_len_q;
				lse_pkg::ADDR_WAIT_LEN: rdata_q <= wait_len_q;
				lse_pkg::ADDR_LTHR_LO: rdata_q <= lthr_lo_q;
				lse_pkg::ADDR_LTHR_HI: rdata_q <= lthr_hi_q;
				default: rdata_q <= 8'h00;
			endcase
		end
	end

	// integration clock enable and step counter run only while timing
	assign running = (state_q == lse_pkg::ST_INTEG) || (state_q == lse_pkg::ST_WAIT);
	assign tick = running && (tick_q == 6'(lse_pkg::TICK_CYCLES - 1));
	assign step_end = tick && (step_q == 12'(STEP_TICKS - 1));

	always_ff @(posedge mclk_in) begin
		if (!nrst_in || !running || state_d == lse_pkg::ST_IDLE
				|| state_d == lse_pkg::ST_SLEEP) begin
			tick_q <= 6'h00;
			step_q <= 12'h000;
		end else begin
			tick_q <= tick ? 6'h00 : tick_q + 6'h01;
			if (tick) begin
				step_q <= step_end ? 12'h000 : step_q + 12'h001;
			end
		end
	end

	// measure and wait sequencing
	always_comb begin
		state_d = state_q;
		per_d = per_q;
		str_d = str_q;
		done_d = 1'b0;
		case (state_q)
			lse_pkg::ST_SLEEP: begin
				if (power_up) begin
					state_d = lse_pkg::ST_IDLE;
				end
			end
			lse_pkg::ST_IDLE: begin
				if (measure) begin
					state_d = lse_pkg::ST_INTEG;
					per_d = integ_len_q;
				end
			end
			lse_pkg::ST_INTEG: begin
				if (!measure) begin
					state_d = lse_pkg::ST_IDLE;
				end else if (step_end) begin
					if (per_q == lse_pkg::TERMINAL_COUNT) begin
						done_d = 1'b1;
						str_d = 4'h0;
						if (wait_en) begin
							state_d = lse_pkg::ST_WAIT;
							per_d = wait_len_q;
						end else begin
							per_d = integ_len_q;
						end
					end else begin
						per_d = per_q - 8'h01;
					end
				end
			end
			lse_pkg::ST_WAIT: begin
				if (!measure) begin
					state_d = lse_pkg::ST_IDLE;
				end else if (step_end) begin
					if (wait_stretch_in && str_q != 4'(lse_pkg::STRETCH_FACTOR - 1)) begin
						str_d = str_q + 4'h1;
					end else begin
						str_d = 4'h0;
						if (per_q == lse_pkg::TERMINAL_COUNT) begin
							state_d = lse_pkg::ST_INTEG;
							per_d = integ_len_q;
						end else begin
							per_d = per_q - 8'h01;
						end
					end
				end
			end
			default: state_d = lse_pkg::ST_SLEEP;
		endcase
		if (!power_up) begin
			state_d = lse_pkg::ST_SLEEP;
		end
	end

	always_ff @(posedge mclk_in) begin
		if (!nrst_in) begin
			state_q <= lse_pkg::ST_SLEEP;
			per_q <= lse_pkg::TERMINAL_COUNT;
			str_q <= 4'h0;
			done_q <= 1'b0;
		end else begin
			state_q <= state_d;
			per_q <= per_d;
			str_q <= str_d;
			done_q <= done_d;
		end
	end

	// low threshold comparison on each visible result
	always_ff @(posedge mclk_in) begin
		if (!nrst_in) begin
			below_q <= 1'b0;
		end else if (vis_valid_in) begin
			below_q <= vis_result_in < lthr_q;
		end
	end

	assign reg_rdata_out = rdata_q;
	assign osc_enable_out = (state_q != lse_pkg::ST_SLEEP);
	assign conv_enable_out = (state_q == lse_pkg::ST_INTEG);
	assign integ_done_out = done_q;
	assign below_low_out = below_q;
	assign state_out = state_q;

	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!nrst_in);

	sequence s_wait_last_step;
		state_q == lse_pkg::ST_WAIT && step_end && measure && power_up
			&& per_q == lse_pkg::TERMINAL_COUNT && !(wait_stretch_in
			&& str_q != 4'(lse_pkg::STRETCH_FACTOR - 1));
	endsequence

	chk_osc_follows_pon: assert property (1 |=> osc_enable_out == $past(power_up))
		else $error("oscillator enable does not follow power-up bit");
	chk_meas_gate: assert property (!measure |=> !conv_enable_out && state_q != lse_pkg::ST_WAIT)
		else $error("measurement runs with measure enable clear");
	chk_wait_gate: assert property ($rose(state_q == lse_pkg::ST_WAIT) |-> $past(wait_en))
		else $error("wait entered without wait enable");
	chk_terminal_done: assert property (integ_done_out |-> $past(per_q) == lse_pkg::TERMINAL_COUNT
			&& $past(state_q) == lse_pkg::ST_INTEG && $past(step_end))
		else $error("integration ended away from terminal count");
	chk_tick_spacing: assert property (tick |=> !tick [*8])
		else $error("integration clock ticks too close");
	chk_step_count: assert property (tick && measure && power_up |=> step_q
			== ($past(step_end) ? 12'h000 : $past(step_q) + 12'h001))
		else $error("step counter did not advance on integration clock");
	chk_stretch_hold: assert property (state_q == lse_pkg::ST_WAIT && step_end && measure
			&& power_up && wait_stretch_in && str_q != 4'(lse_pkg::STRETCH_FACTOR - 1)
			|=> per_q == $past(per_q) && str_q == $past(str_q) + 4'h1)
		else $error("stretched wait advanced its down counter");
	chk_wait_repeat: assert property (s_wait_last_step |=> state_q == lse_pkg::ST_INTEG
			&& per_q == $past(integ_len_q))
		else $error("wait end did not start a new measurement");
	chk_thr_latch: assert property (reg_wr_in && reg_addr_in == lse_pkg::ADDR_LTHR_HI
			|=> lthr_q == {$past(reg_wdata_in), $past(lthr_lo_q)})
		else $error("threshold not latched on high byte write");
	chk_below_low: assert property (vis_valid_in |=> below_low_out
			== ($past(vis_result_in) < $past(lthr_q)))
		else $error("low threshold compare wrong");
	chk_no_wait: assert property (state_q == lse_pkg::ST_INTEG && step_end && measure
			&& power_up && !wait_en && per_q == lse_pkg::TERMINAL_COUNT
			|=> state_q == lse_pkg::ST_INTEG && per_q == $past(integ_len_q))
		else $error("back-to-back measurement did not restart");
	chk_sleep_on_off: assert property (!power_up |=> state_q == lse_pkg::ST_SLEEP)
		else $error("power-down did not return to sleep");
endmodule : lse_core
`default_nettype wire

// ### lse_host.sv
/*
 * host model: issues byte writes and reads on the core's register port.
 * assumes strobes are sampled on the rising clock edge, one access a cycle.
 */
`timescale 1ns/1ps
`default_nettype none
module lse_host (
	// clock
	input wire logic mclk_in,
	// register port
	output logic [7:0] addr_out,
	output logic wr_out,
	output logic rd_out,
	output logic [7:0] wdata_out,
	input wire logic [7:0] rdata_in
);
	initial begin
		addr_out = 8'h00;
		wr_out = 1'b0;
		rd_out = 1'b0;
		wdata_out = 8'h00;
	end
	// one whole byte a write; caller orders low byte before high byte
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge mclk_in);
		addr_out = a;
		wdata_out = d;
		wr_out = 1'b1;
		@(negedge mclk_in);
		wr_out = 1'b0;
		// released lines show the inverse, not the last value
		addr_out = ~a;
		wdata_out = ~d;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge mclk_in);
		addr_out = a;
		rd_out = 1'b1;
		@(negedge mclk_in);
		rd_out = 1'b0;
		addr_out = ~a;
		d = rdata_in;
	endtask : rd
endmodule : lse_host
`default_nettype wire

// ### tb_lse_core.sv
/*
 * testbench for the enable, timing and threshold core.
 * assumes the host model above and STEP_TICKS shortened to 2.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_lse_core;
	logic mclk_in = 1'b0;
	logic nrst_in = 1'b0;
	logic [7:0] addr, wdata, rdata, v;
	logic wr, rd, done, below, osc, conv;
	logic stretch = 1'b0;
	logic vvalid = 1'b0;
	logic [15:0] vres = 16'h0000;
	logic [1:0] st;
	int mismatches = 0;
	int checks_done = 0;
	int n;
	always #12.5 mclk_in = ~mclk_in;
	lse_core #(.STEP_TICKS(2)) lse_core_i (.mclk_in(mclk_in), .nrst_in(nrst_in),
		.reg_addr_in(addr), .reg_wr_in(wr), .reg_rd_in(rd), .reg_wdata_in(wdata),
		.reg_rdata_out(rdata), .wait_stretch_in(stretch), .vis_valid_in(vvalid),
		.vis_result_in(vres), .osc_enable_out(osc), .conv_enable_out(conv),
		.integ_done_out(done), .below_low_out(below), .state_out(st));
	lse_host lse_host_i (.mclk_in(mclk_in), .addr_out(addr), .wr_out(wr), .rd_out(rd),
		.wdata_out(wdata), .rdata_in(rdata));
	task automatic summarize();
		if (mismatches == 0 && checks_done > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : summarize
	task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp8
	task automatic cmpn(input int got, input int exp);
		checks_done++;
		if (got != exp) begin
			mismatches++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmpn
	task automatic vis(input logic [15:0] r, input logic [7:0] exp);
		@(negedge mclk_in);
		vres = r;
		vvalid = 1'b1;
		@(negedge mclk_in);
		vvalid = 1'b0;
		vres = ~r;
		@(negedge mclk_in);
		cmp8({7'h00, below}, exp);
	endtask : vis
	task automatic span_done(output int c);
		c = 0;
		do begin
			@(negedge mclk_in);
			c++;
		end while (done !== 1'b1 && c < 5000);
	endtask : span_done
	task automatic span_wait(output int c);
		c = 0;
		while (st === 2'b11 && c < 5000) begin
			@(negedge mclk_in);
			c++;
		end
	endtask : span_wait
	task automatic t_reset();
		cmp8({6'h00, st, osc, conv}, 8'h00);
		lse_host_i.rd(8'h80, v);
		cmp8(v, 8'h00);
		lse_host_i.rd(8'h81, v);
		cmp8(v, 8'h00);
		lse_host_i.rd(8'h83, v);
		cmp8(v, 8'h00);
		lse_host_i.rd(8'h84, v);
		cmp8(v, 8'h00);
		lse_host_i.wr(8'h82, 8'h5a);
		lse_host_i.rd(8'h82, v);
		cmp8(v, 8'h00);
	endtask : t_reset
	task automatic t_thresh();
		lse_host_i.wr(8'h84, 8'h34);
		vis(16'h0000, 8'h00);
		lse_host_i.wr(8'h85, 8'h12);
		lse_host_i.rd(8'h84, v);
		cmp8(v, 8'h34);
		vis(16'h1233, 8'h01);
		vis(16'h1234, 8'h00);
	endtask : t_thresh
	task automatic t_timing();
		lse_host_i.wr(8'h81, 8'h01);
		lse_host_i.wr(8'h80, 8'h03);
		@(negedge mclk_in);
		cmp8({6'h00, st, osc, conv}, 8'h06);
		@(negedge mclk_in);
		cmp8({6'h00, st, osc, conv}, 8'h0b);
		span_done(n);
		cmpn(n, 220);
		cmp8({6'h00, st}, 8'h02);
		span_done(n);
		cmpn(n, 220);
		cmp8({7'h00, done}, 8'h01);
		lse_host_i.wr(8'h80, 8'h01);
		@(negedge mclk_in);
		cmp8({6'h00, st}, 8'h01);
		lse_host_i.wr(8'h83, 8'h01);
		lse_host_i.wr(8'h80, 8'h0b);
		span_done(n);
		@(negedge mclk_in);
		cmp8({6'h00, st}, 8'h03);
		span_wait(n);
		cmpn(n + 1, 220);
		lse_host_i.wr(8'h80, 8'h01);
		lse_host_i.wr(8'h83, 8'h00);
		stretch = 1'b1;
		lse_host_i.wr(8'h80, 8'h0b);
		span_done(n);
		@(negedge mclk_in);
		span_wait(n);
		cmpn(n + 1, 1320);
		lse_host_i.wr(8'h80, 8'h00);
		@(negedge mclk_in);
		cmp8({6'h00, st, osc, conv}, 8'h00);
	endtask : t_timing
	// reset in the middle of an integration returns everything to sleep
	task automatic t_midrst();
		lse_host_i.wr(8'h80, 8'h03);
		repeat (80) @(negedge mclk_in);
		cmp8({6'h00, st, osc, conv}, 8'h0b);
		nrst_in = 1'b0;
		repeat (2) @(negedge mclk_in);
		nrst_in = 1'b1;
		cmp8({6'h00, st, osc, conv}, 8'h00);
		lse_host_i.rd(8'h80, v);
		cmp8(v, 8'h00);
		lse_host_i.rd(8'h81, v);
		cmp8(v, 8'h00);
	endtask : t_midrst
	initial begin
		repeat (20) @(negedge mclk_in);
		nrst_in = 1'b1;
		t_reset();
		t_thresh();
		t_timing();
		t_midrst();
		summarize();
	end
	initial begin
		#(25 * 12000);
		mismatches++;
		summarize();
	end
endmodule : tb_lse_core
`default_nettype wire
